/* hw/smc_pkg.sv */
// constants, register map and state encoding for the string move and compare unit
package smc_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_GR0 = 8'h08;
	localparam logic [7:0] OFF_GR2 = 8'h0C;
	localparam logic [7:0] OFF_ADDR1 = 8'h10;
	localparam logic [7:0] OFF_LEN1 = 8'h14;
	localparam logic [7:0] OFF_ADDR2 = 8'h18;
	localparam logic [7:0] OFF_LEN2 = 8'h1C;
	localparam logic [7:0] OFF_PAIR_HI = 8'h20;
	localparam logic [7:0] OFF_PAIR_LO = 8'h24;
	localparam logic [7:0] OFF_GR1 = 8'h28;
	// control and status fields
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_RESUME_BIT = 9;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_SUSP_BIT = 1;
	localparam int STAT_CC_LSB = 4;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// operation selects
	localparam logic [7:0] MOVE_TRANSLATE_UNTIL_OP = 8'h00;
	localparam logic [7:0] MOVE_PAD_OP = 8'h01;
	localparam logic [7:0] MOVE_DEFAULT_PAD_OP = 8'h21;
	localparam logic [7:0] COMPARE_TEXT_OP = 8'h02;
	localparam logic [7:0] COMPARE_TEXT_DEFAULT_PAD_OP = 8'h22;
	localparam logic [7:0] PACK_DECIMAL_OP = 8'h03;
	localparam logic [7:0] PACK_DECIMAL_ABSOLUTE_OP = 8'h23;
	localparam logic [7:0] BINARY_TO_PACKED_STORE_OP = 8'h6E;
	// condition flags, bit 3 leftmost
	localparam logic [3:0] CC_NONE = 4'h0;
	localparam logic [3:0] CC_L = 4'h1;
	localparam logic [3:0] CC_G = 4'h2;
	localparam logic [3:0] CC_V = 4'h4;
	localparam logic [3:0] CC_C = 4'h8;
	// character and sign codes
	localparam logic [7:0] PAD_DEFAULT = 8'h20;
	localparam logic [3:0] SIGN_PLUS = 4'hC;
	localparam logic [3:0] SIGN_MINUS = 4'hD;
	localparam logic [3:0] SIGN_ALT_MINUS = 4'hB;
	// binary to packed geometry
	localparam int BP_DIGITS = 31;
	localparam logic [6:0] BP_LAST_STEP = 7'h3F;
	localparam logic [6:0] BP_LAST_BYTE = 7'h0F;
	localparam logic [3:0] BCD_ADJ_MIN = 4'h5;
	localparam logic [3:0] BCD_ADJ = 4'h3;

	typedef enum logic [3:0] {
		SMC_IDLE, SMC_TOP, SMC_RD_SRC, SMC_RD_TAB, SMC_WR_DST, SMC_RD_A, SMC_CMP_B, SMC_RD_B,
		SMC_BP_CONV, SMC_BP_WR, SMC_PK_SIGN, SMC_PK_DIG, SMC_PK_WR, SMC_PK_SCAN
	} smc_state_e;
endpackage

/* hw/smc_string_unit.sv */
// string move, translate, compare, pack and binary-to-packed engine
// Notes on behaviour
// - binary-to-packed store flags zero 0000, negative 0001, positive 0010.
// - translate-until compares each argument byte with low byte of register 0.
// - register 2 zero passes bytes; else byte indexes table at that address.
// - escape byte sets leftmost flag and ends without storing it.
// - translate loop runs until escape, destination full or source used up.
// - translate flags: 0000 moved, overflow when full, leftmost on escape.
// - register 1 ends holding address of next unmoved source byte.
// - bytes move in ascending address order; bad overlap is undefined.
// - exhausted source pads destination with register 0 byte or space.
// - destination full first gives overflow flag only; complete move 0000.
// - compare walks byte pairs, stops at first mismatch or both exhausted.
// - shorter compare string extended with register 0 pad or space.
// - register 1 gets matched second-operand byte count excluding its pads.
// - compare flags: equal 0000, first greater 0010, first smaller 0001.
// - pack reads zoned digits with trailing sign; lengths are value plus one.
// - packed result shorter than destination gets leading zero digits.
// - binary-to-packed writes sixteen bytes, leftmost at operand address.
// - generated signs C plus, D minus; B also minus on input.
// - absolute pack forces positive sign code.
// - too short destination keeps low digits, drops high; overflow set only if a dropped digit is nonzero.
`timescale 1ns/1ps
module smc_string_unit (
	input wire logic clk, // processor clock
	input wire logic rst_b, // synchronous reset
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_we, // register write strobe
	input wire logic reg_re, // register read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic suspend_req, // pending interrupt, stop at byte boundary of move, translate or compare (pack ignores it)
	output logic mem_req, // memory byte access request
	output logic mem_we, // memory access is a write
	output logic [31:0] mem_addr, // memory byte address
	output logic [7:0] mem_wdata, // memory write byte
	input wire logic [7:0] mem_rdata, // memory read byte, valid with ack
	input wire logic mem_ack, // memory access complete
	output logic busy, // instruction in progress
	output logic done // instruction finished
);
	typedef struct packed {
		smc_pkg::smc_state_e st;
		logic [7:0] op;
		logic susp;
		logic done;
		logic [3:0] cc;
		logic [31:0] gr0;
		logic [31:0] gr1;
		logic [31:0] gr2;
		logic [31:0] a1;
		logic [31:0] l1;
		logic [31:0] a2;
		logic [31:0] l2;
		logic [31:0] hi;
		logic [31:0] lo;
		logic [31:0] rdata;
		logic [7:0] tmp;
		logic [6:0] cnt;
		logic [123:0] bcd;
		logic [63:0] mag;
		logic neg;
		logic nz;
		logic ovf;
		logic req;
		logic we;
		logic [31:0] maddr;
		logic [7:0] wdata;
	} smc_state_s;

	smc_state_s s;
	smc_state_s n;

	function automatic logic is_minus(input logic [3:0] code);
		is_minus = (code == smc_pkg::SIGN_MINUS) || (code == smc_pkg::SIGN_ALT_MINUS);
	endfunction

	// one shift-add-3 step of binary to decimal conversion
	function automatic logic [123:0] dabble(input logic [123:0] v, input logic b);
		logic [123:0] t;
		t = v;
		for (int i = 0; i < smc_pkg::BP_DIGITS; i++) begin
			if (t[4*i +: 4] >= smc_pkg::BCD_ADJ_MIN) begin
				t[4*i +: 4] = t[4*i +: 4] + smc_pkg::BCD_ADJ;
			end
		end
		dabble = {t[122:0], b};
	endfunction

	logic is_xlat;
	logic is_move;
	logic is_cmp;
	logic [7:0] pad;
	logic [127:0] packed_str;
	logic [7:0] arg;
	logic arg_go;
	logic [7:0] bval;
	logic cmp_go;
	logic [3:0] dig;
	logic dig_go;

	assign is_xlat = s.op == smc_pkg::MOVE_TRANSLATE_UNTIL_OP;
	assign is_move = (s.op == smc_pkg::MOVE_PAD_OP) || (s.op == smc_pkg::MOVE_DEFAULT_PAD_OP);
	assign is_cmp = (s.op == smc_pkg::COMPARE_TEXT_OP) || (s.op == smc_pkg::COMPARE_TEXT_DEFAULT_PAD_OP);
	assign pad = (s.op[5]) ? smc_pkg::PAD_DEFAULT : s.gr0[7:0];
	assign packed_str = {s.bcd, (s.neg ? smc_pkg::SIGN_MINUS : smc_pkg::SIGN_PLUS)};

	always_comb begin
		n = s;
		n.done = 1'b0;
		n.rdata = smc_pkg::RST_WORD;
		arg = 8'h00;
		arg_go = 1'b0;
		bval = 8'h00;
		cmp_go = 1'b0;
		dig = 4'h0;
		dig_go = 1'b0;
		if (reg_re) begin
			case (reg_addr)
				smc_pkg::OFF_CTRL: n.rdata = {24'h000000, s.op};
				smc_pkg::OFF_STATUS: n.rdata = {24'h000000, s.cc, 2'b00, s.susp, (s.st != smc_pkg::SMC_IDLE)};
				smc_pkg::OFF_GR0: n.rdata = s.gr0;
				smc_pkg::OFF_GR2: n.rdata = s.gr2;
				smc_pkg::OFF_ADDR1: n.rdata = s.a1;
				smc_pkg::OFF_LEN1: n.rdata = s.l1;
				smc_pkg::OFF_ADDR2: n.rdata = s.a2;
				smc_pkg::OFF_LEN2: n.rdata = s.l2;
				smc_pkg::OFF_PAIR_HI: n.rdata = s.hi;
				smc_pkg::OFF_PAIR_LO: n.rdata = s.lo;
				smc_pkg::OFF_GR1: n.rdata = s.gr1;
				default: n.rdata = smc_pkg::RST_WORD;
			endcase
		end
		// writes land only while idle
		if (reg_we && s.st == smc_pkg::SMC_IDLE) begin
			case (reg_addr)
				smc_pkg::OFF_GR0: n.gr0 = reg_wdata;
				smc_pkg::OFF_GR2: n.gr2 = reg_wdata;
				smc_pkg::OFF_ADDR1: n.a1 = reg_wdata;
				smc_pkg::OFF_LEN1: n.l1 = reg_wdata;
				smc_pkg::OFF_ADDR2: n.a2 = reg_wdata;
				smc_pkg::OFF_LEN2: n.l2 = reg_wdata;
				smc_pkg::OFF_PAIR_HI: n.hi = reg_wdata;
				smc_pkg::OFF_PAIR_LO: n.lo = reg_wdata;
				smc_pkg::OFF_GR1: n.gr1 = reg_wdata;
				smc_pkg::OFF_CTRL: begin
					n.op = reg_wdata[7:0];
					if (reg_wdata[smc_pkg::CTRL_START_BIT]) begin
						n.susp = 1'b0;
						n.cc = smc_pkg::CC_NONE;
						n.ovf = 1'b0;
						n.cnt = 7'h00;
						n.st = smc_pkg::SMC_TOP;
						if (reg_wdata[7:0] == smc_pkg::BINARY_TO_PACKED_STORE_OP) begin
							n.neg = s.hi[31];
							n.nz = |{s.hi, s.lo};
							n.mag = s.hi[31] ? (64'h0 - {s.hi, s.lo}) : {s.hi, s.lo};
							n.bcd = '0;
							n.st = smc_pkg::SMC_BP_CONV;
						end else if ((reg_wdata[7:0] == smc_pkg::PACK_DECIMAL_OP)
							|| (reg_wdata[7:0] == smc_pkg::PACK_DECIMAL_ABSOLUTE_OP)) begin
							// lengths plus one, walk from the right end
							n.a1 = s.a1 + s.l1;
							n.l1 = s.l1 + 32'h1;
							n.a2 = s.a2 + s.l2;
							n.l2 = s.l2 + 32'h1;
							n.nz = 1'b0;
							n.st = smc_pkg::SMC_PK_SIGN;
						end else if (!reg_wdata[smc_pkg::CTRL_RESUME_BIT]) begin
							// resume keeps the running count
							// match count starts at zero; moves reload it at the top
							n.gr1 = 32'h0;
						end
					end
				end
				default: ;
			endcase
		end

		unique case (s.st)
			smc_pkg::SMC_IDLE: ;
			smc_pkg::SMC_TOP: begin
				if (suspend_req) begin
					n.susp = 1'b1;
					n.st = smc_pkg::SMC_IDLE;
					if (!is_cmp) begin
						n.gr1 = s.a2;
					end
				end else if (is_xlat) begin
					if (s.l2 == 32'h0) begin
						n.cc = smc_pkg::CC_NONE;
						n.st = smc_pkg::SMC_IDLE;
						n.done = 1'b1;
					end else if (s.l1 == 32'h0) begin
						n.cc = smc_pkg::CC_V;
						n.st = smc_pkg::SMC_IDLE;
						n.done = 1'b1;
					end else begin
						n.req = 1'b1;
						n.we = 1'b0;
						n.maddr = s.a2;
						n.st = smc_pkg::SMC_RD_SRC;
					end
					n.gr1 = s.a2;
				end else if (is_move) begin
					if (s.l1 == 32'h0) begin
						n.cc = (s.l2 != 32'h0) ? smc_pkg::CC_V : smc_pkg::CC_NONE;
						n.st = smc_pkg::SMC_IDLE;
						n.done = 1'b1;
					end else if (s.l2 != 32'h0) begin
						n.req = 1'b1;
						n.we = 1'b0;
						n.maddr = s.a2;
						n.st = smc_pkg::SMC_RD_SRC;
					end else begin
						n.req = 1'b1;
						n.we = 1'b1;
						n.maddr = s.a1;
						n.wdata = pad;
						n.st = smc_pkg::SMC_WR_DST;
					end
					n.gr1 = s.a2;
				end else begin
					if (s.l1 == 32'h0 && s.l2 == 32'h0) begin
						n.cc = smc_pkg::CC_NONE;
						n.st = smc_pkg::SMC_IDLE;
						n.done = 1'b1;
					end else if (s.l1 != 32'h0) begin
						n.req = 1'b1;
						n.we = 1'b0;
						n.maddr = s.a1;
						n.st = smc_pkg::SMC_RD_A;
					end else begin
						n.tmp = pad;
						n.st = smc_pkg::SMC_CMP_B;
					end
				end
			end
			smc_pkg::SMC_RD_SRC: begin
				if (mem_ack) begin
					n.req = 1'b0;
					if (is_xlat && s.gr2 != 32'h0) begin
						n.req = 1'b1;
						n.maddr = s.gr2 + {24'h000000, mem_rdata};
						n.st = smc_pkg::SMC_RD_TAB;
					end else begin
						arg = mem_rdata;
						arg_go = 1'b1;
					end
				end
			end
			smc_pkg::SMC_RD_TAB: begin
				if (mem_ack) begin
					n.req = 1'b0;
					arg = mem_rdata;
					arg_go = 1'b1;
				end
			end
			smc_pkg::SMC_WR_DST: begin
				if (mem_ack) begin
					n.req = 1'b0;
					n.a1 = s.a1 + 32'h1;
					n.l1 = s.l1 - 32'h1;
					if (s.l2 != 32'h0) begin
						n.a2 = s.a2 + 32'h1;
						n.l2 = s.l2 - 32'h1;
					end
					n.st = smc_pkg::SMC_TOP;
				end
			end
			smc_pkg::SMC_RD_A: begin
				if (mem_ack) begin
					n.req = 1'b0;
					n.tmp = mem_rdata;
					n.st = smc_pkg::SMC_CMP_B;
				end
			end
			smc_pkg::SMC_CMP_B: begin
				if (s.l2 != 32'h0) begin
					n.req = 1'b1;
					n.we = 1'b0;
					n.maddr = s.a2;
					n.st = smc_pkg::SMC_RD_B;
				end else begin
					bval = pad;
					cmp_go = 1'b1;
				end
			end
			smc_pkg::SMC_RD_B: begin
				if (mem_ack) begin
					n.req = 1'b0;
					bval = mem_rdata;
					cmp_go = 1'b1;
				end
			end
			smc_pkg::SMC_BP_CONV: begin
				n.bcd = dabble(s.bcd, s.mag[63]);
				n.mag = {s.mag[62:0], 1'b0};
				n.cnt = s.cnt + 7'h01;
				if (s.cnt == smc_pkg::BP_LAST_STEP) begin
					n.cnt = 7'h00;
					n.st = smc_pkg::SMC_BP_WR;
				end
			end
			smc_pkg::SMC_BP_WR: begin
				if (!s.req) begin
					n.req = 1'b1;
					n.we = 1'b1;
					n.maddr = s.a2 + {25'h0, s.cnt};
					n.wdata = packed_str[{4'hF - s.cnt[3:0], 3'b000} +: 8];
				end else if (mem_ack) begin
					n.req = 1'b0;
					n.cnt = s.cnt + 7'h01;
					if (s.cnt == smc_pkg::BP_LAST_BYTE) begin
						n.cc = !s.nz ? smc_pkg::CC_NONE : (s.neg ? smc_pkg::CC_L : smc_pkg::CC_G);
						n.st = smc_pkg::SMC_IDLE;
						n.done = 1'b1;
					end
				end
			end
			smc_pkg::SMC_PK_SIGN: begin
				if (!s.req) begin
					n.req = 1'b1;
					n.we = 1'b0;
					n.maddr = s.a2;
				end else if (mem_ack) begin
					n.req = 1'b0;
					n.neg = is_minus(mem_rdata[7:4]) && !s.op[5];
					n.tmp = {mem_rdata[3:0], (n.neg ? smc_pkg::SIGN_MINUS : smc_pkg::SIGN_PLUS)};
					n.nz = mem_rdata[3:0] != 4'h0;
					n.a2 = s.a2 - 32'h1;
					n.l2 = s.l2 - 32'h1;
					n.st = smc_pkg::SMC_PK_WR;
				end
			end
			smc_pkg::SMC_PK_DIG: begin
				if (s.l2 == 32'h0) begin
					dig_go = 1'b1;
				end else if (!s.req) begin
					n.req = 1'b1;
					n.we = 1'b0;
					n.maddr = s.a2;
				end else if (mem_ack) begin
					n.req = 1'b0;
					dig = mem_rdata[3:0];
					dig_go = 1'b1;
					n.nz = s.nz | (mem_rdata[3:0] != 4'h0);
					n.a2 = s.a2 - 32'h1;
					n.l2 = s.l2 - 32'h1;
				end
			end
			smc_pkg::SMC_PK_WR: begin
				if (!s.req) begin
					n.req = 1'b1;
					n.we = 1'b1;
					n.maddr = s.a1;
					n.wdata = s.tmp;
				end else if (mem_ack) begin
					n.req = 1'b0;
					n.a1 = s.a1 - 32'h1;
					n.l1 = s.l1 - 32'h1;
					n.cnt = 7'h00;
					n.st = (s.l1 == 32'h1) ? smc_pkg::SMC_PK_SCAN : smc_pkg::SMC_PK_DIG;
				end
			end
			smc_pkg::SMC_PK_SCAN: begin
				if (s.l2 == 32'h0) begin
					n.cc = (s.ovf ? smc_pkg::CC_V : smc_pkg::CC_NONE)
						| (!s.nz ? smc_pkg::CC_NONE : (s.neg ? smc_pkg::CC_L : smc_pkg::CC_G));
					n.st = smc_pkg::SMC_IDLE;
					n.done = 1'b1;
				end else if (!s.req) begin
					n.req = 1'b1;
					n.we = 1'b0;
					n.maddr = s.a2;
				end else if (mem_ack) begin
					n.req = 1'b0;
					n.ovf = s.ovf | (mem_rdata[3:0] != 4'h0);
					n.a2 = s.a2 - 32'h1;
					n.l2 = s.l2 - 32'h1;
				end
			end
		endcase

		if (arg_go) begin
			if (is_xlat && arg == s.gr0[7:0]) begin
				n.cc = smc_pkg::CC_C;
				n.gr1 = s.a2;
				n.st = smc_pkg::SMC_IDLE;
				n.done = 1'b1;
			end else begin
				n.req = 1'b1;
				n.we = 1'b1;
				n.maddr = s.a1;
				n.wdata = arg;
				n.st = smc_pkg::SMC_WR_DST;
			end
		end
		if (cmp_go) begin
			if (s.tmp == bval) begin
				if (s.l1 != 32'h0) begin
					n.a1 = s.a1 + 32'h1;
					n.l1 = s.l1 - 32'h1;
				end
				if (s.l2 != 32'h0) begin
					n.a2 = s.a2 + 32'h1;
					n.l2 = s.l2 - 32'h1;
					n.gr1 = s.gr1 + 32'h1;
				end
				n.st = smc_pkg::SMC_TOP;
			end else begin
				n.cc = (s.tmp > bval) ? smc_pkg::CC_G : smc_pkg::CC_L;
				n.st = smc_pkg::SMC_IDLE;
				n.done = 1'b1;
			end
		end
		if (dig_go) begin
			if (!s.cnt[0]) begin
				n.tmp[3:0] = dig;
				n.cnt = 7'h01;
			end else begin
				n.tmp[7:4] = dig;
				n.cnt = 7'h00;
				n.st = smc_pkg::SMC_PK_WR;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign reg_rdata = s.rdata;
	assign mem_req = s.req;
	assign mem_we = s.we;
	assign mem_addr = s.maddr;
	assign mem_wdata = s.wdata;
	assign busy = s.st != smc_pkg::SMC_IDLE;
	assign done = s.done;
endmodule // smc_string_unit

/* testbench/smc_mem_model.sv */
// byte memory answering the unit's memory port
`timescale 1ns/1ps
module smc_mem_model (
	input wire logic clk, // clock
	input wire logic rst_b, // reset, active low
	input wire logic mem_req, // access request
	input wire logic mem_we, // write access
	input wire logic [31:0] mem_addr, // byte address
	input wire logic [7:0] mem_wdata, // write byte
	input wire logic [1:0] lat, // extra wait cycles
	output logic [7:0] mem_rdata, // read byte
	output logic mem_ack // access done
);
	logic [7:0] mem [0:255];
	logic [1:0] cnt;
	logic gap;
	always @(posedge clk) begin
		if (!rst_b) begin
			mem_ack <= 1'b0;
			cnt <= 2'h0;
			gap <= 1'b0;
			mem_rdata <= 8'hA5;
		end else if (mem_ack || gap || !mem_req || cnt != lat) begin
			// one idle cycle after each ack so one access is never answered twice
			mem_ack <= 1'b0;
			gap <= mem_ack;
			cnt <= (mem_req && !mem_ack && !gap) ? cnt + 2'h1 : 2'h0;
			// released data line does not hold its last value
			mem_rdata <= ~mem_rdata;
		end else begin
			mem_ack <= 1'b1;
			cnt <= 2'h0;
			if (mem_we)
				mem[mem_addr[7:0]] <= mem_wdata;
			else
				mem_rdata <= mem[mem_addr[7:0]];
		end
	end
endmodule // smc_mem_model

/* testbench/smc_string_unit_checker.sv */
// port assertions for the string move and compare unit
`timescale 1ns/1ps
module smc_string_unit_checker (
	input wire logic clk, // clock
	input wire logic rst_b, // reset
	input wire logic [7:0] reg_addr, // reg address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_we, // write strobe
	input wire logic reg_re, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic mem_req, // mem request
	input wire logic mem_we, // mem write
	input wire logic [31:0] mem_addr, // mem address
	input wire logic [7:0] mem_wdata, // mem byte
	input wire logic mem_ack, // mem ack
	input wire logic busy, // running
	input wire logic done // finished
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	chk_req_held: assert property (mem_req && !mem_ack |=> mem_req)
		else $error("request dropped before ack");
	chk_addr_stable: assert property (mem_req && !mem_ack |=> $stable(mem_addr) && $stable(mem_we))
		else $error("address moved during access");
	chk_wdata_stable: assert property (mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
		else $error("write byte moved during access");
	chk_next_access: assert property (mem_ack |=> !mem_req || $changed(mem_addr) || $changed(mem_we))
		else $error("access repeated after ack");
	chk_start_runs: assert property (reg_we && !busy && reg_addr == smc_pkg::OFF_CTRL
		&& reg_wdata[smc_pkg::CTRL_START_BIT] |=> busy)
		else $error("start did not run");
	chk_done_end: assert property (done |-> !busy && $past(busy) ##1 !done)
		else $error("done not a single end pulse");
	chk_idle_quiet: assert property (!busy |-> !mem_req)
		else $error("memory access while idle");
	chk_read_window: assert property (!reg_re |=> reg_rdata == 32'h0)
		else $error("read data outside window");
	chk_status_busy: assert property (reg_re && reg_addr == smc_pkg::OFF_STATUS
		|=> reg_rdata[smc_pkg::STAT_BUSY_BIT] == $past(busy))
		else $error("status busy bit wrong");
	cover property (done);
	cover property ($fell(busy) && !done);
	cover property (mem_ack && mem_we);
endmodule // smc_string_unit_checker
bind smc_string_unit smc_string_unit_checker u_smc_string_unit_checker (.clk, .rst_b, .reg_addr, .reg_wdata,
	.reg_we, .reg_re, .reg_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .busy, .done);

/* testbench/smc_string_unit_tb.sv */
// self-checking bench for the string move and compare unit
`timescale 1ns/1ps
module smc_string_unit_tb;
	logic clk, rst_b, reg_we, reg_re, suspend_req, mem_req, mem_we, mem_ack, busy, done;
	logic [7:0] reg_addr, mem_wdata, mem_rdata;
	logic [31:0] reg_wdata, reg_rdata, mem_addr;
	logic [1:0] lat;
	int n_fail, n_compared, i;
	smc_string_unit u_smc_string_unit (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
		.suspend_req, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .busy, .done);
	smc_mem_model u_smc_mem_model (.clk, .rst_b, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat, .mem_rdata,
		.mem_ack);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic complete_run();
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	task automatic cmp_reg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		cmp(reg_rdata & m, exp);
	endtask
	task automatic cmp_mem(input logic [7:0] a, input logic [7:0] e);
		cmp({24'h0, u_smc_mem_model.mem[a]}, {24'h0, e});
	endtask
	task automatic setup(input logic [31:0] a1, l1, a2, l2);
		wr(smc_pkg::OFF_ADDR1, a1);
		wr(smc_pkg::OFF_LEN1, l1);
		wr(smc_pkg::OFF_ADDR2, a2);
		wr(smc_pkg::OFF_LEN2, l2);
	endtask
	// start, optionally suspend after stop cycles, then check flags
	task automatic go(input logic [7:0] op, input logic res, input int stop, input logic [3:0] cc);
		int nd;
		nd = 0;
		wr(smc_pkg::OFF_CTRL, {22'h0, res, 1'b1, op});
		for (int k = 0; k < 3000; k++) begin
			@(posedge clk);
			suspend_req <= (k >= stop);
			@(negedge clk);
			if (done === 1'b1)
				nd++;
			if (busy !== 1'b1)
				break;
		end
		@(posedge clk);
		suspend_req <= 1'b0;
		cmp(32'(nd), stop < 999 ? 32'h0 : 32'h1);
		if (stop < 999)
			cmp_reg(smc_pkg::OFF_STATUS, 32'h2, 32'h3);
		else
			cmp_reg(smc_pkg::OFF_STATUS, {24'h0, cc, 4'h0});
	endtask
	task automatic mv(input logic [7:0] op, input int l1, l2, n, input logic [3:0] cc, input logic [7:0] pad, off,
		input int stop);
		for (int k = 0; k < 9; k++)
			u_smc_mem_model.mem[48 + k] = 8'h00;
		setup(32'h30, 32'(l1), 32'h10, 32'(l2));
		go(op, 1'b0, stop, cc);
		if (stop < 999)
			go(op, 1'b1, 9999, cc);
		cmp_reg(smc_pkg::OFF_GR1, 32'(16 + n));
		for (int k = 0; k <= l1; k++)
			cmp_mem(8'(48 + k), k < n ? 8'(97 + k) - off : (k < l1 ? pad : 8'h00));
	endtask
	task automatic cp(input logic [7:0] op, input logic [31:0] a1, l1, a2, l2, input logic [3:0] cc, input int n);
		setup(a1, l1, a2, l2);
		go(op, 1'b0, 9999, cc);
		cmp_reg(smc_pkg::OFF_GR1, 32'(n));
	endtask
	task automatic pk(input logic [7:0] op, input logic [31:0] l1, input logic [3:0] cc, input logic [23:0] e);
		for (int k = 0; k < 3; k++)
			u_smc_mem_model.mem[112 + k] = 8'h00;
		setup(32'h70, l1, 32'h60, 32'h2);
		go(op, 1'b0, 9999, cc);
		for (int k = 0; k < 3; k++)
			cmp_mem(8'(112 + k), e[23 - 8 * k -: 8]);
	endtask
	task automatic bp(input logic [31:0] hi, lo, input logic [3:0] cc, input logic [7:0] b14, b15);
		for (int k = 0; k < 16; k++)
			u_smc_mem_model.mem[144 + k] = 8'hEE;
		wr(smc_pkg::OFF_PAIR_HI, hi);
		wr(smc_pkg::OFF_PAIR_LO, lo);
		wr(smc_pkg::OFF_ADDR2, 32'h90);
		go(8'h6E, 1'b0, 9999, cc);
		for (int k = 0; k < 16; k++)
			cmp_mem(8'(144 + k), k == 15 ? b15 : (k == 14 ? b14 : 8'h00));
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		complete_run();
	end
	initial begin
		reg_we = 1'b0;
		reg_re = 1'b0;
		suspend_req = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		lat = 2'h0;
		n_fail = 0;
		n_compared = 0;
		rst_b = 1'b0;
		// source bytes at 10, lookup table at 80 maps 61 to 41
		for (i = 0; i < 256; i++)
			u_smc_mem_model.mem[i] = i < 16 ? 8'h00 : (i < 24 ? 8'(i + 81) : 8'(i - 160));
		for (i = 0; i < 6; i++) begin
			u_smc_mem_model.mem[64 + i] = 8'(65 + i);
			u_smc_mem_model.mem[80 + i] = i < 3 ? 8'(65 + i) : 8'h44;
		end
		{u_smc_mem_model.mem[96], u_smc_mem_model.mem[97], u_smc_mem_model.mem[98]} = 24'h3132D3;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i <= 44; i += 4)
			cmp_reg(8'(i), 32'h0);
		cmp_reg(8'h40, 32'h0);
		wr(smc_pkg::OFF_GR0, 32'h2A);
		cmp_reg(smc_pkg::OFF_GR0, 32'h2A);
		mv(8'h00, 4, 2, 2, 4'h0, 8'h00, 8'h00, 9999);
		mv(8'h00, 1, 3, 1, 4'h4, 8'h00, 8'h00, 9999);
		mv(8'h01, 3, 1, 1, 4'h0, 8'h2A, 8'h00, 9999);
		mv(8'h21, 3, 1, 1, 4'h0, 8'h20, 8'h00, 9999);
		mv(8'h01, 1, 2, 1, 4'h4, 8'h2A, 8'h00, 9999);
		lat <= 2'h1;
		mv(8'h01, 8, 8, 8, 4'h0, 8'h2A, 8'h00, 10);
		wr(smc_pkg::OFF_GR2, 32'h80);
		wr(smc_pkg::OFF_GR0, 32'h43);
		mv(8'h00, 5, 5, 2, 4'h8, 8'h00, 8'h20, 9999);
		wr(smc_pkg::OFF_GR0, 32'h44);
		cp(8'h22, 32'h40, 32'h3, 32'h50, 32'h6, 4'h1, 3);
		cp(8'h02, 32'h40, 32'h3, 32'h50, 32'h6, 4'h0, 6);
		cp(8'h22, 32'h50, 32'h6, 32'h40, 32'h3, 4'h2, 3);
		cp(8'h02, 32'h40, 32'h2, 32'h50, 32'h2, 4'h0, 2);
		pk(8'h03, 32'h2, 4'h1, 24'h00123D);
		pk(8'h23, 32'h2, 4'h2, 24'h00123C);
		pk(8'h03, 32'h0, 4'h5, 24'h3D0000);
		bp(32'hFFFFFFFF, 32'hFFFFFF85, 4'h1, 8'h12, 8'h3D);
		bp(32'h0, 32'h0, 4'h0, 8'h00, 8'h0C);
		bp(32'h0, 32'h7B, 4'h2, 8'h12, 8'h3C);
		complete_run();
	end
endmodule // smc_string_unit_tb
